// ### pkg/adsq_defines.vh
// Register map, field positions and timing counts for the converter control block.
// Assumes inclusion by bare name from the design files.
`ifndef ADSQ_DEFINES_VH
`define ADSQ_DEFINES_VH

`define ADSQ_ADDR_W 3
`define ADSQ_OFF_CTRL 3'h0
`define ADSQ_OFF_CLK 3'h1
`define ADSQ_OFF_RES_LO 3'h2
`define ADSQ_OFF_RES_HI 3'h3
`define ADSQ_OFF_INT_STAT 3'h4
`define ADSQ_OFF_INT_MASK 3'h5

// Control register fields
`define ADSQ_CTRL_START 7
`define ADSQ_CTRL_EOC_N 6
`define ADSQ_CTRL_PCFG_HI 5
`define ADSQ_CTRL_PCFG_LO 3
`define ADSQ_CTRL_CH_HI 2
`define ADSQ_CTRL_CH_LO 0
`define ADSQ_CTRL_RST 8'h40

// Clock register fields
`define ADSQ_CLK_PWR_N 7
`define ADSQ_CLK_SEL_HI 2
`define ADSQ_CLK_SEL_LO 0
`define ADSQ_CLK_RST 8'h80

// Clock select codes
`define ADSQ_CSEL_DIV2 3'h0
`define ADSQ_CSEL_DIV8 3'h1
`define ADSQ_CSEL_DIV32 3'h2

// Half periods of the conversion clock in system clocks, less one
`define ADSQ_HALF_DIV2 5'h00
`define ADSQ_HALF_DIV8 5'h03
`define ADSQ_HALF_DIV32 5'h0F

`define ADSQ_CONV_TICKS 5'h10
`define ADSQ_RES_W 12
`define ADSQ_NUM_CH 8
`define ADSQ_PCFG_ALL 3'h7

`endif

// ### sim/adsq_ctrl_checker.sv
// Concurrent checks on the converter control block ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module adsq_ctrl_checker (
  input wire ref_clk,
  input wire rst,
  input wire rd_en,
  input wire [7:0] rdata,
  input wire [7:0] port_pull_en,
  input wire [7:0] port_direction_control,
  input wire [7:0] analog_inputs,
  input wire [7:0] pull_en_eff,
  input wire [7:0] dir_eff,
  input wire converter_on,
  input wire engine_reset,
  input wire sample_req,
  input wire irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_rdata_quiet: assert property (!rd_en |=> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_pull_cut: assert property (
    !rst |=> pull_en_eff == ($past(port_pull_en) & ~analog_inputs))
    else $error("pull enable kept on analog pin");
  a_dir_force: assert property (
    !rst |=> dir_eff == ($past(port_direction_control) | analog_inputs))
    else $error("direction not forced on analog pin");
  a_pins_low: assert property ((analog_inputs & (analog_inputs + 8'h01)) == 8'h00)
    else $error("analog pins not a low group");
  a_idle_off: assert property (
    analog_inputs == 8'h00 && $stable(analog_inputs) |-> !converter_on)
    else $error("converter on with no analog pin");
  a_off_reset: assert property (
    !converter_on && $past(converter_on) == 1'h0 |-> engine_reset)
    else $error("engine released while converter off");
  a_req_pulse: assert property (sample_req |=> !sample_req)
    else $error("sample request longer than one cycle");
  a_req_live: assert property (sample_req |-> converter_on)
    else $error("sample request while converter off");
  cover property (sample_req);
  cover property ($rose(irq));
  cover property (analog_inputs == 8'hFF);
endmodule

bind adsq_ctrl adsq_ctrl_checker u_chk (.ref_clk(ref_clk), .rst(rst), .rd_en(rd_en),
  .rdata(rdata), .port_pull_en(port_pull_en), .port_direction_control(port_direction_control),
  .analog_inputs(analog_inputs), .pull_en_eff(pull_en_eff), .dir_eff(dir_eff),
  .converter_on(converter_on), .engine_reset(engine_reset), .sample_req(sample_req), .irq(irq));

// ### sim/adsq_ctrl_tb.sv
// Self-checking bench for the converter control block.
// Assumes adsq_ctrl and its register map header, 100 MHz clock.
`timescale 1ns/1ps
`include "adsq_defines.vh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module adsq_ctrl_tb;
  reg ref_clk = 1'h0, rst = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00, pp = 8'h00, pd = 8'h00, d;
  reg [11:0] smp = 12'h000;
  wire [7:0] rdata, an, pe, de;
  wire [2:0] sel;
  wire on, er, req, irq;
  integer bad_count = 0, cmp_count = 0, i, p, n, dv, req_n = 0;
  time t0;
  always @(posedge ref_clk) if (req) req_n <= req_n + 1;
  adsq_ctrl uut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .sample_data(smp), .port_pull_en(pp),
    .port_direction_control(pd), .analog_sel(sel), .analog_inputs(an), .pull_en_eff(pe),
    .dir_eff(de), .converter_on(on), .engine_reset(er), .sample_req(req), .irq(irq));
  task wr(input [2:0] a, input [7:0] v);
    @(posedge ref_clk) begin addr <= a; wdata <= v; wr_en <= 1'h1; end
    @(posedge ref_clk) wr_en <= 1'h0;
  endtask
  task rd(input [2:0] a);
    @(posedge ref_clk) begin addr <= a; rd_en <= 1'h1; end
    @(posedge ref_clk) rd_en <= 1'h0;
    #1 d = rdata;
  endtask
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function [7:0] exp_an(input [2:0] c);
    exp_an = (c == 3'h0) ? 8'h00 : 8'hFF >> (3'h7 - c);
  endfunction
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    d = $urandom(74);
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    rd(`ADSQ_OFF_CTRL); `CHK("ctrl_rst", 8'h40, d)
    rd(`ADSQ_OFF_CLK); `CHK("clk_rst", 8'h80, d)
    `CHK("on_rst", 1'h0, on)
    $display("test reset done");
    wr(`ADSQ_OFF_CLK, 8'h01);
    for (p = 0; p < 8; p++) begin
      n = $urandom % 8;
      @(posedge ref_clk) begin pp <= $urandom; pd <= $urandom; end
      wr(`ADSQ_OFF_CTRL, {2'h0, p[2:0], n[2:0]});
      settle;
      `CHK("analog", exp_an(p[2:0]), an)
      `CHK("sel", n[2:0], sel)
      `CHK("pull", pp & ~exp_an(p[2:0]), pe)
      `CHK("dir", pd | exp_an(p[2:0]), de)
      `CHK("on", p != 0, on)
    end
    $display("test pins done");
    wr(`ADSQ_OFF_CLK, 8'h81);
    settle;
    `CHK("pwr_off", 1'h0, on)
    for (i = 0; i < 3; i++) begin
      dv = 2 << (2 * i);
      wr(`ADSQ_OFF_CLK, {5'h00, i[2:0]});
      wr(`ADSQ_OFF_INT_MASK, {7'h00, i != 1});
      @(posedge ref_clk) smp <= $urandom;
      wr(`ADSQ_OFF_CTRL, 8'hB8 | i[2:0]);
      rd(`ADSQ_OFF_CTRL); `CHK("eoc_hold", 1'h1, d[6])
      `CHK("eng_rst", 1'h1, er)
      wr(`ADSQ_OFF_CTRL, 8'h38 | i[2:0]);
      t0 = $time;
      n = 0;
      while (d[6] && n < 400) begin rd(`ADSQ_OFF_CTRL); n++; end
      if (d[6]) begin bad_count++; end_sim; end
      `CHK("dur", 1'h1, $time - t0 >= 160 * dv && $time - t0 <= 160 * dv + 100)
      `CHK("irq", i != 1, irq)
      `CHK("req", i + 1, req_n)
      `CHK("eng_run", 1'h0, er)
      rd(`ADSQ_OFF_INT_STAT); `CHK("stat", 8'h01, d)
      if (i == 1) begin
        wr(`ADSQ_OFF_INT_MASK, 8'h01);
        settle;
        `CHK("irq_unmask", 1'h1, irq)
      end
      wr(`ADSQ_OFF_RES_HI, 8'h5A);
      wr(`ADSQ_OFF_RES_LO, 8'hA5);
      rd(`ADSQ_OFF_RES_HI); `CHK("res_hi", smp[11:4], d)
      rd(`ADSQ_OFF_RES_LO); `CHK("res_lo", {smp[3:0], 4'h0}, d)
      wr(`ADSQ_OFF_INT_STAT, 8'h01);
      settle;
      `CHK("irq_clr", 1'h0, irq)
      $display("test conversion %0d done", i);
    end
    rd(3'h6); `CHK("unmapped", 8'h00, d)
    $display("test unmapped done");
    end_sim;
  end
endmodule

// ### src/adsq_ctrl.v
// Converter control: registers, start protocol, sequencer, result and interrupt.
// Assumes a synchronous register port and an external analog sample engine.
`timescale 1ns/1ps
`include "adsq_defines.vh"

module adsq_ctrl (
  input wire ref_clk,
  input wire rst,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire [11:0] sample_data,
  input wire [7:0] port_pull_en,
  input wire [7:0] port_direction_control,
  output reg [2:0] analog_sel,
  output reg [7:0] analog_inputs,
  output reg [7:0] pull_en_eff,
  output reg [7:0] dir_eff,
  output reg converter_on,
  output reg engine_reset,
  output reg sample_req,
  output reg irq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_HOLD = 2'd1;
  localparam ST_CONV = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [2:0] channel_select_r;
  reg [2:0] pin_config_r;
  reg start_r;
  reg end_of_conversion_n_r;
  reg [2:0] clock_select_r;
  reg converter_power_n_r;
  reg [11:0] result_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [4:0] tick_cnt_r;
  reg int_stat_r;
  reg int_mask_r;
  reg [4:0] half_cnt;
  reg [7:0] ana_map;
  wire tick;
  wire enabled;
  wire wr_ctrl;
  wire start_fall;
  wire conv_done;
  wire wr_clk;
  wire wr_mask;
  wire wr_stat;
  wire conv_tick;
  wire first_tick;
  reg [2:0] channel_select_nxt;
  reg [2:0] pin_config_nxt;
  reg start_nxt;
  reg end_of_conversion_n_nxt;
  reg [2:0] clock_select_nxt;
  reg converter_power_n_nxt;
  reg [11:0] result_nxt;
  reg [4:0] tick_cnt_nxt;
  reg int_stat_nxt;
  reg int_mask_nxt;
  reg sample_req_nxt;
  reg [7:0] rdata_nxt;
  reg [2:0] analog_sel_nxt;
  reg [7:0] analog_inputs_nxt;
  reg [7:0] pull_en_eff_nxt;
  reg [7:0] dir_eff_nxt;
  reg converter_on_nxt;
  reg engine_reset_nxt;
  reg irq_nxt;

  assign wr_ctrl = wr_en && (addr == `ADSQ_OFF_CTRL);
  // Start protocol: falling edge written by software
  assign start_fall = wr_ctrl && start_r && !wdata[`ADSQ_CTRL_START];
  assign enabled = !converter_power_n_r && (pin_config_r != 3'h0);
  assign conv_done = (state_r == ST_CONV) && tick && (tick_cnt_r == `ADSQ_CONV_TICKS - 5'h01);

  always @* begin
    case (clock_select_r)
      `ADSQ_CSEL_DIV2: half_cnt = `ADSQ_HALF_DIV2;
      `ADSQ_CSEL_DIV8: half_cnt = `ADSQ_HALF_DIV8;
      `ADSQ_CSEL_DIV32: half_cnt = `ADSQ_HALF_DIV32;
      default: half_cnt = `ADSQ_HALF_DIV32;
    endcase
  end

  // Pin config value N from 1 to 7 makes the lowest N+1 pins analog, 0 none; 111 gives all eight
  always @* begin
    case (pin_config_r)
      3'h0: ana_map = 8'h00;
      3'h1: ana_map = 8'h03;
      3'h2: ana_map = 8'h07;
      3'h3: ana_map = 8'h0F;
      3'h4: ana_map = 8'h1F;
      3'h5: ana_map = 8'h3F;
      3'h6: ana_map = 8'h7F;
      default: ana_map = 8'hFF;
    endcase
  end

  adsq_presc u_presc (
    .ref_clk(ref_clk),
    .clr(state_r != ST_CONV),
    .half_cnt(half_cnt),
    .tick(tick)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (wr_ctrl && wdata[`ADSQ_CTRL_START] && !start_r)
          state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (start_fall)
          state_nxt = enabled ? ST_CONV : ST_IDLE;
      end
      ST_CONV: begin
        if (wr_ctrl && wdata[`ADSQ_CTRL_START])
          state_nxt = ST_HOLD;
        else if (!enabled)
          state_nxt = ST_IDLE;
        else if (conv_done)
          state_nxt = ST_DONE;
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign wr_clk = wr_en && (addr == `ADSQ_OFF_CLK);
  assign wr_mask = wr_en && (addr == `ADSQ_OFF_INT_MASK);
  assign wr_stat = wr_en && (addr == `ADSQ_OFF_INT_STAT);
  assign conv_tick = (state_r == ST_CONV) && tick;
  // Gated by enable so no request escapes while powering down
  assign first_tick = conv_tick && (tick_cnt_r == 5'h00) && enabled;

  // Sequencer state and conversion clock count
  always @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      tick_cnt_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  always @* begin
    tick_cnt_nxt = tick_cnt_r;
    if (state_r != ST_CONV) begin
      tick_cnt_nxt = 5'h00;
    end else if (tick) begin
      tick_cnt_nxt = tick_cnt_r + 5'h01;
    end
  end

  // Control register fields written by software
  always @* begin
    channel_select_nxt = channel_select_r;
    pin_config_nxt = pin_config_r;
    start_nxt = start_r;
    if (wr_ctrl) begin
      channel_select_nxt = wdata[`ADSQ_CTRL_CH_HI:`ADSQ_CTRL_CH_LO];
      pin_config_nxt = wdata[`ADSQ_CTRL_PCFG_HI:`ADSQ_CTRL_PCFG_LO];
      start_nxt = wdata[`ADSQ_CTRL_START];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      channel_select_r <= 3'h0;
      pin_config_r <= 3'h0;
      start_r <= 1'b0;
    end else begin
      channel_select_r <= channel_select_nxt;
      pin_config_r <= pin_config_nxt;
      start_r <= start_nxt;
    end
  end

  // Clock register: power control and divider code
  always @* begin
    converter_power_n_nxt = converter_power_n_r;
    clock_select_nxt = clock_select_r;
    if (wr_clk) begin
      converter_power_n_nxt = wdata[`ADSQ_CLK_PWR_N];
      clock_select_nxt = wdata[`ADSQ_CLK_SEL_HI:`ADSQ_CLK_SEL_LO];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      converter_power_n_r <= 1'b1;
      clock_select_r <= 3'h0;
    end else begin
      converter_power_n_r <= converter_power_n_nxt;
      clock_select_r <= clock_select_nxt;
    end
  end

  // End flag: forced high while start held, low once a conversion ends
  always @* begin
    end_of_conversion_n_nxt = end_of_conversion_n_r;
    if (state_nxt == ST_HOLD) begin
      end_of_conversion_n_nxt = 1'b1;
    end else if (conv_done) begin
      end_of_conversion_n_nxt = 1'b0;
    end
  end

  // Engine samples the routed input on the first conversion clock
  always @* begin
    sample_req_nxt = first_tick;
  end

  // Result captured on the closing conversion clock
  always @* begin
    result_nxt = result_r;
    if (conv_done) begin
      result_nxt = sample_data;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      end_of_conversion_n_r <= 1'b1;
      sample_req <= 1'b0;
      result_r <= 12'h000;
    end else begin
      end_of_conversion_n_r <= end_of_conversion_n_nxt;
      sample_req <= sample_req_nxt;
      result_r <= result_nxt;
    end
  end

  // Set wins over write-one-to-clear
  always @* begin
    int_stat_nxt = int_stat_r;
    if (conv_done) begin
      int_stat_nxt = 1'b1;
    end else if (wr_stat && wdata[0]) begin
      int_stat_nxt = 1'b0;
    end
  end

  always @* begin
    int_mask_nxt = int_mask_r;
    if (wr_mask) begin
      int_mask_nxt = wdata[0];
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      int_stat_r <= 1'b0;
      int_mask_r <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
    end
  end

  // Read data stand only in the cycle after the read strobe
  always @* begin
    rdata_nxt = 8'h00;
    if (rd_en) begin
      case (addr)
        `ADSQ_OFF_CTRL: rdata_nxt = {start_r, end_of_conversion_n_r, pin_config_r,
                                     channel_select_r};
        `ADSQ_OFF_CLK: rdata_nxt = {converter_power_n_r, 4'h0, clock_select_r};
        `ADSQ_OFF_RES_LO: rdata_nxt = {result_r[3:0], 4'h0};
        `ADSQ_OFF_RES_HI: rdata_nxt = result_r[11:4];
        `ADSQ_OFF_INT_STAT: rdata_nxt = {7'h00, int_stat_r};
        `ADSQ_OFF_INT_MASK: rdata_nxt = {7'h00, int_mask_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // Pin side and status outputs, all registered
  always @* begin
    analog_sel_nxt = channel_select_r;
    analog_inputs_nxt = ana_map;
    pull_en_eff_nxt = port_pull_en & ~ana_map;
    dir_eff_nxt = port_direction_control | ana_map;
    converter_on_nxt = enabled;
    engine_reset_nxt = (state_nxt == ST_HOLD) || !enabled;
    irq_nxt = int_stat_nxt && int_mask_r;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      analog_sel <= 3'h0;
      analog_inputs <= 8'h00;
      pull_en_eff <= 8'h00;
      dir_eff <= 8'hFF;
    end else begin
      analog_sel <= analog_sel_nxt;
      analog_inputs <= analog_inputs_nxt;
      pull_en_eff <= pull_en_eff_nxt;
      dir_eff <= dir_eff_nxt;
    end
  end

  // Engine held in reset while start is held or the converter is not enabled
  always @(posedge ref_clk) begin
    if (rst) begin
      converter_on <= 1'b0;
      engine_reset <= 1'b1;
      irq <= 1'b0;
    end else begin
      converter_on <= converter_on_nxt;
      engine_reset <= engine_reset_nxt;
      irq <= irq_nxt;
    end
  end
endmodule

// ### src/adsq_presc.v
// Conversion clock prescaler: emits one tick per conversion clock period.
// Assumes a single system clock and a synchronous active-high clear.
`timescale 1ns/1ps
`include "adsq_defines.vh"

module adsq_presc (
  input wire ref_clk,
  input wire clr,
  input wire [4:0] half_cnt,
  output reg tick
);
  reg [4:0] cnt_r;
  reg phase_r;

  always @(posedge ref_clk) begin
    if (clr) begin
      cnt_r <= 5'h00;
      phase_r <= 1'b0;
      tick <= 1'b0;
    end else if (cnt_r >= half_cnt) begin
      cnt_r <= 5'h00;
      phase_r <= ~phase_r;
      tick <= phase_r;
    end else begin
      cnt_r <= cnt_r + 5'h01;
      tick <= 1'b0;
    end
  end
endmodule
